// ---- hw/fsp_status_bank.sv ----
// Status and protection register bank of a serial NOR flash.
// Assumes a decoded-command source on the link clock, and a program/erase
// engine on the system clock that pulses done when an operation ends.
// How it works
// - While busy, every command is dropped except suspend of an engine op.
// - Busy clears when the status write or engine operation finishes.
// - Write-armed latch is read-only and set by Write Enable.
// - Latch clears at reset, Write Disable, program, erase, status write.
// - Three block-protect bits, non-volatile, writable, factory zero.
// - Origin bit: 0 protects from top, 1 from bottom; default 0.
// - Granule bit: 1 counts 4 KB sectors, 0 counts 64 KB blocks.
// - Invert bit swaps protected and unprotected regions; default 0.
// - Lock mode 0: pin ignored, writes allowed with latch armed.
// - Lock mode 1, write-protect pin low and quad off: status writes refused.
// - Lock mode 1 and pin high: writes allowed with latch armed.
// - Busy, latch and paused flag are never written from status write data.
// - Write Enable before status write targets non-volatile copies.
// - Volatile enable before status write touches only volatile copies.
// - Locked state blocks all configuration and lock bits, both copies.
// - Volatile status write leaves one-time lock bits untouched.
// - Paused flag set by suspend, cleared by resume or reset.
// - One-time lock bits reset 0, set singly, never clear again.
// - Shared pin is hold at 0, reset at 1, only without quad.
// - Two drive-strength bits select read drive; default 0.
// - High-speed quad bit enables high-frequency mode; default 0.
// - Low four bits of third byte reserved, read as zero.
// - Reset clears both copies; software reset loads volatile copies from non-volatile.
// - Quad enable turns protect and hold pins into data lines.
`timescale 1ns/1ns
module fsp_status_bank (
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link clock and its reset
    input wire logic clk_link_i,
    input wire logic link_rst_i,
    // Link command port
    input wire logic lnk_cmd_valid_i,
    input wire fsp_pkg::fsp_cmd_t lnk_cmd_i,
    output logic lnk_cmd_ready_o,
    // Write-protect pin, active low
    input wire logic wp_n_i,
    // Program/erase engine
    output logic eng_start_o,
    output logic [7:0] eng_op_o,
    input wire logic eng_done_i,
    input wire logic [19:0] eng_addr_i,
    output logic eng_prot_hit_o,
    // Status bytes for reads
    output logic [7:0] status_protect_reg_o,
    output logic [7:0] status_lock_config_reg_o,
    output logic [7:0] pin_drive_config_reg_o,
    // Pin and driver configuration
    output logic shared_pin_is_reset_o,
    output logic shared_pin_is_hold_o,
    output logic wp_pin_active_o,
    output logic quad_io_enable_o,
    output logic [1:0] drive_strength_o,
    output logic high_speed_quad_mode_o,
    output logic [2:0] otp_lock_o
);
    import fsp_pkg::*;

    // Link side state
    fsp_cmd_t hold_r;
    logic req_tgl_r;
    logic ack_s;
    // System side state
    logic [1:0] sys_s;
    logic req_seen_r;
    logic cmd_take;
    logic [7:0] op;
    logic wp_s;
    logic busy_r;
    logic busy_eng_r;
    logic write_armed_latch_r;
    logic vol_armed_r;
    logic paused_flag_r;
    logic [15:0] sw_cnt_r;
    logic [7:0] nv1_r, nv2_r, nv3_r;
    logic [7:0] vol1_r, vol2_r, vol3_r;
    logic [7:0] pend1_r, pend2_r, pend3_r;
    logic [2:0] pend_en_r;
    logic [2:0] wr_en;
    logic is_sw, is_pe, locked, accept, sw_take, vol_take, nv_take;
    logic sw_done, prot_hit;
    logic [7:0] m1, m2, m3;

    // Link: capture command, flip request toggle, wait for ack
    always_ff @(posedge clk_link_i)
    begin
        if (link_rst_i)
        begin
            hold_r <= '0;
            req_tgl_r <= 1'b0;
            lnk_cmd_ready_o <= 1'b0;
        end
        else if (lnk_cmd_valid_i && lnk_cmd_ready_o)
        begin
            hold_r <= lnk_cmd_i;
            req_tgl_r <= ~req_tgl_r;
            lnk_cmd_ready_o <= 1'b0;
        end
        else
            lnk_cmd_ready_o <= (req_tgl_r == ack_s);
    end

    // Ack toggle back into the link domain
    fsp_sync #(.W(1)) u_ack_sync (
        .clk_i(clk_link_i),
        .rst_i(link_rst_i),
        .d_i(req_seen_r),
        .q_o(ack_s)
    );

    // Request toggle and write-protect pin into the system domain
    fsp_sync #(.W(2)) u_sys_sync (
        .clk_i(clk_sys_i),
        .rst_i(sys_rst_i),
        .d_i({req_tgl_r, wp_n_i}),
        .q_o(sys_s)
    );
    assign wp_s = sys_s[0];

    // Held command is stable until the ack returns
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            req_seen_r <= 1'b0;
        else
            req_seen_r <= sys_s[1];
    end
    assign cmd_take = sys_s[1] ^ req_seen_r;
    assign op = hold_r.opcode;

    // Command classes and write permission
    always_comb
    begin
        is_sw = (op == OP_WRITE_STATUS_1) || (op == OP_WRITE_STATUS_2)
            || (op == OP_WRITE_STATUS_3);
        is_pe = (op == OP_PAGE_PROGRAM) || (op == OP_SECTOR_ERASE)
            || (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE_A)
            || (op == OP_CHIP_ERASE_B);
        // pin matters only in lock mode
        locked = vol1_r[LOCK_MODE_BIT] && !wp_s && !vol2_r[QUAD_BIT];
        accept = cmd_take && (!busy_r
            || (op == OP_SUSPEND && busy_eng_r));
        sw_take = accept && is_sw;
        // volatile path wins once armed by its enable
        vol_take = sw_take && !locked && vol_armed_r;
        // armed latch selects the non-volatile path
        nv_take = sw_take && !locked && !vol_armed_r
            && write_armed_latch_r;
        wr_en = '0;
        if (op == OP_WRITE_STATUS_1)
            wr_en = {1'b0, hold_r.nbytes >= 2'd2, 1'b1};
        else if (op == OP_WRITE_STATUS_2)
            wr_en = 3'b010;
        else if (op == OP_WRITE_STATUS_3)
            wr_en = 3'b100;
    end

    // Byte routing: second register takes byte0 unless chained after first
    logic [7:0] in2;
    assign in2 = (op == OP_WRITE_STATUS_1) ? hold_r.byte1 : hold_r.byte0;

    // Masks of the configuration fields under pending write
    // volatile status bits are never in the masks
    assign m1 = pend_en_r[0] ? SR1_CFG_MASK : 8'h00;
    assign m2 = pend_en_r[1] ? SR2_CFG_MASK : 8'h00;
    assign m3 = pend_en_r[2] ? SR3_CFG_MASK : 8'h00;
    assign sw_done = busy_r && !busy_eng_r && (sw_cnt_r == 16'h0001);

    // Busy flag and status write timer
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            busy_r <= 1'b0;
            busy_eng_r <= 1'b0;
            sw_cnt_r <= '0;
        end
        else if (nv_take)
        begin
            busy_r <= 1'b1;
            busy_eng_r <= 1'b0;
            sw_cnt_r <= 16'(STATUS_WRITE_CYC);
        end
        else if (accept && is_pe && write_armed_latch_r)
        begin
            busy_r <= 1'b1;
            busy_eng_r <= 1'b1;
        end
        // Done racing a suspend is kept, so resume cannot hang
        else if (accept && op == OP_SUSPEND)
        begin
            busy_r <= 1'b0;
            busy_eng_r <= busy_eng_r && !eng_done_i;
        end
        // Resume only revives an engine operation still pending
        else if (accept && op == OP_RESUME && paused_flag_r && busy_eng_r)
            busy_r <= 1'b1;
        // busy ends with the operation, suspended or not
        else if (sw_done || (busy_eng_r && eng_done_i))
        begin
            busy_r <= 1'b0;
            busy_eng_r <= 1'b0;
            sw_cnt_r <= '0;
        end
        else if (sw_cnt_r != 16'h0000)
            sw_cnt_r <= sw_cnt_r - 16'h0001;
    end

    // Write-armed latch and volatile arming
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            write_armed_latch_r <= 1'b0;
            vol_armed_r <= 1'b0;
        end
        else if (accept)
        begin
            vol_armed_r <= (op == OP_WRITE_ENABLE_VOL);
            if (op == OP_WRITE_ENABLE)
                write_armed_latch_r <= 1'b1;
            // cleared by disable, program, erase, status write, software reset
            else if (op == OP_WRITE_DISABLE || is_pe || is_sw
                || op == OP_SOFT_RESET)
                write_armed_latch_r <= 1'b0;
        end
    end

    // paused flag by suspend and resume
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            paused_flag_r <= 1'b0;
        else if (accept && op == OP_SUSPEND)
            paused_flag_r <= 1'b1;
        else if (accept && op == OP_RESUME)
            paused_flag_r <= 1'b0;
    end

    // Pending non-volatile image held over the write time
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            pend1_r <= CFG_RESET;
            pend2_r <= CFG_RESET;
            pend3_r <= CFG_RESET;
            pend_en_r <= '0;
        end
        else if (nv_take)
        begin
            pend1_r <= hold_r.byte0;
            pend2_r <= in2;
            pend3_r <= hold_r.byte0;
            pend_en_r <= wr_en;
        end
    end

    // Non-volatile copies, factory zero
    // block-protect bits stored here
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            nv1_r <= CFG_RESET;
            nv2_r <= CFG_RESET;
            nv3_r <= CFG_RESET;
        end
        else if (sw_done)
        begin
            nv1_r <= (nv1_r & ~m1) | (pend1_r & m1);
            nv2_r <= (nv2_r & ~m2) | (pend2_r & m2)
                | (pend_en_r[1] ? (pend2_r & SR2_OTP_MASK) : 8'h00);
            nv3_r <= (nv3_r & ~m3) | (pend3_r & m3);
        end
    end

    // Volatile copies steer the block
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            vol1_r <= CFG_RESET;
            vol2_r <= CFG_RESET;
            vol3_r <= CFG_RESET;
        end
        else if (accept && op == OP_SOFT_RESET)
        begin
            vol1_r <= nv1_r & SR1_CFG_MASK;
            vol2_r <= nv2_r & SR2_CFG_MASK;
            vol3_r <= nv3_r & SR3_CFG_MASK;
        end
        // volatile write has no lock bits in its masks
        else if (vol_take)
        begin
            if (wr_en[0])
                vol1_r <= hold_r.byte0 & SR1_CFG_MASK;
            if (wr_en[1])
                vol2_r <= in2 & SR2_CFG_MASK;
            if (wr_en[2])
                vol3_r <= hold_r.byte0 & SR3_CFG_MASK;
        end
        else if (sw_done)
        begin
            vol1_r <= (vol1_r & ~m1) | (pend1_r & m1);
            vol2_r <= (vol2_r & ~m2) | (pend2_r & m2);
            vol3_r <= (vol3_r & ~m3) | (pend3_r & m3);
        end
    end

    // Engine start and suspend/resume forwarding
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            eng_start_o <= 1'b0;
            eng_op_o <= 8'h00;
        end
        else
        begin
            eng_start_o <= accept && ((is_pe && write_armed_latch_r)
                || op == OP_SUSPEND
                || (op == OP_RESUME && paused_flag_r));
            if (accept)
                eng_op_o <= op;
        end
    end

    fsp_protect_map u_map (
        .granule_i(vol1_r[GRANULE_BIT]),
        .origin_i(vol1_r[ORIGIN_BIT]),
        .invert_i(vol2_r[INVERT_BIT]),
        .bp_i(vol1_r[BP_LSB +: 3]),
        .addr_i(eng_addr_i),
        .hit_o(prot_hit)
    );

    // Registered status and configuration outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            status_protect_reg_o <= 8'h00;
            status_lock_config_reg_o <= 8'h00;
            pin_drive_config_reg_o <= 8'h00;
            shared_pin_is_reset_o <= 1'b0;
            shared_pin_is_hold_o <= 1'b0;
            wp_pin_active_o <= 1'b0;
            quad_io_enable_o <= 1'b0;
            drive_strength_o <= 2'h0;
            high_speed_quad_mode_o <= 1'b0;
            otp_lock_o <= 3'h0;
            eng_prot_hit_o <= 1'b0;
        end
        else
        begin
            status_protect_reg_o <= {vol1_r[7:2], write_armed_latch_r,
                busy_r};
            status_lock_config_reg_o <= {paused_flag_r, vol2_r[INVERT_BIT],
                nv2_r[OTP_LSB +: 3], 1'b0, vol2_r[QUAD_BIT], 1'b0};
            pin_drive_config_reg_o <= {vol3_r[7:4], 4'h0};
            // shared pin function only without quad
            shared_pin_is_reset_o <= !vol2_r[QUAD_BIT]
                && vol3_r[SHARED_PIN_BIT];
            shared_pin_is_hold_o <= !vol2_r[QUAD_BIT]
                && !vol3_r[SHARED_PIN_BIT];
            // protect pin function off in quad mode
            wp_pin_active_o <= !vol2_r[QUAD_BIT];
            quad_io_enable_o <= vol2_r[QUAD_BIT];
            drive_strength_o <= vol3_r[DRIVE_LSB +: 2];
            high_speed_quad_mode_o <= vol3_r[HSQ_BIT];
            otp_lock_o <= nv2_r[OTP_LSB +: 3];
            eng_prot_hit_o <= prot_hit;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_busy_blocks_start: assert property (
        busy_r && cmd_take && op != OP_SUSPEND |=> !eng_start_o)
        else $error("command started while busy");
    a_busy_clears: assert property (
        nv_take |=> busy_r [*8] ##[1:600] !busy_r)
        else $error("status write busy window wrong");
    a_latch_sets: assert property (
        accept && op == OP_WRITE_ENABLE |=> write_armed_latch_r)
        else $error("write enable did not arm latch");
    a_latch_clears: assert property (
        accept && (is_sw || is_pe || op == OP_WRITE_DISABLE)
        |=> !write_armed_latch_r)
        else $error("latch not cleared");
    a_lock_refuses: assert property (
        sw_take && locked |=> $stable(vol1_r) && $stable(vol2_r)
            && !(busy_r && !$past(busy_r)))
        else $error("locked status write accepted");
    a_vol_only: assert property (
        vol_take |=> $stable(nv1_r) && $stable(nv2_r) && $stable(nv3_r))
        else $error("volatile write touched non-volatile copy");
    a_otp_sticky: assert property (
        ((nv2_r & $past(nv2_r)) & SR2_OTP_MASK)
            == ($past(nv2_r) & SR2_OTP_MASK))
        else $error("lock bit cleared");
    a_paused_set: assert property (
        accept && op == OP_SUSPEND |=> ##1 status_lock_config_reg_o[7])
        else $error("suspend did not set paused flag");
    a_reload_vol: assert property (
        accept && op == OP_SOFT_RESET
        |=> vol1_r == ($past(nv1_r) & SR1_CFG_MASK))
        else $error("software reset did not reload");

    c_nv_write: cover property (nv_take ##[1:600] sw_done);
    c_vol_write: cover property (vol_take);
    c_suspend: cover property (accept && op == OP_SUSPEND);
endmodule // fsp_status_bank

// ---- hw/fsp_pkg.sv ----
// Constants and carrier types of the flash status and protection bank.
// Assumes a 100 MHz system clock; link commands arrive already decoded.
package fsp_pkg;

    // System clock period and the status write duration
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_STATUS_WRITE_NS = 5000;
    localparam int STATUS_WRITE_CYC =
        (T_STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_WRITE_ENABLE_VOL = 8'h50;
    localparam logic [7:0] OP_WRITE_STATUS_1 = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS_2 = 8'h31;
    localparam logic [7:0] OP_WRITE_STATUS_3 = 8'h11;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_SOFT_RESET = 8'h99;

    // Field positions in the three status bytes
    localparam int BUSY_BIT = 0;
    localparam int ARMED_BIT = 1;
    localparam int BP_LSB = 2;
    localparam int ORIGIN_BIT = 5;
    localparam int GRANULE_BIT = 6;
    localparam int LOCK_MODE_BIT = 7;
    localparam int QUAD_BIT = 1;
    localparam int OTP_LSB = 3;
    localparam int INVERT_BIT = 6;
    localparam int PAUSED_BIT = 7;
    localparam int HSQ_BIT = 4;
    localparam int DRIVE_LSB = 5;
    localparam int SHARED_PIN_BIT = 7;

    // Writable field masks and reset value
    localparam logic [7:0] SR1_CFG_MASK = 8'hFC;
    localparam logic [7:0] SR2_CFG_MASK = 8'h42;
    localparam logic [7:0] SR2_OTP_MASK = 8'h38;
    localparam logic [7:0] SR3_CFG_MASK = 8'hF0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Array geometry for the protection map
    localparam logic [20:0] ARRAY_BYTES = 21'h100000;
    localparam logic [20:0] BLOCK_BYTES = 21'h010000;
    localparam logic [20:0] SECTOR_BYTES = 21'h001000;

    // One decoded command from the link side
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [1:0] nbytes;
    } fsp_cmd_t;

endpackage

// ---- hw/fsp_sync.sv ----
// Two-flop level synchroniser, W bits wide.
// Each bit must be a level or a slow toggle from another domain.
`timescale 1ns/1ns
module fsp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // Two stages, first read only by the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_r <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule // fsp_sync

// ---- hw/fsp_protect_map.sv ----
// Protected-region decision for one array address.
// Assumes a 1 MB array of 64 KB blocks and 4 KB sectors.
`timescale 1ns/1ns
module fsp_protect_map (
    // Protection fields
    input wire logic granule_i,
    input wire logic origin_i,
    input wire logic invert_i,
    input wire logic [2:0] bp_i,
    // Address under test
    input wire logic [19:0] addr_i,
    output logic hit_o
);
    import fsp_pkg::*;

    logic [20:0] size;
    logic region;

    always_comb
    begin
        size = '0;
        if (granule_i)
        begin
            case (bp_i)
                3'h0: size = '0;
                3'h1: size = SECTOR_BYTES;
                3'h2: size = SECTOR_BYTES << 1;
                3'h3: size = SECTOR_BYTES << 2;
                3'h4, 3'h5: size = SECTOR_BYTES << 3;
                default: size = ARRAY_BYTES;
            endcase
        end
        else
        begin
            case (bp_i)
                3'h0: size = '0;
                3'h1: size = BLOCK_BYTES;
                3'h2: size = BLOCK_BYTES << 1;
                3'h3: size = BLOCK_BYTES << 2;
                3'h4: size = BLOCK_BYTES << 3;
                default: size = ARRAY_BYTES;
            endcase
        end
    end

    always_comb
    begin
        if (origin_i)
            region = {1'b0, addr_i} < size;
        else
            region = ({1'b0, addr_i} + size) >= ARRAY_BYTES;
    end

    assign hit_o = region ^ invert_i;
endmodule // fsp_protect_map

// ---- tb/fsp_host_model.sv ----
// Host-side model issuing decoded commands on the link port.
// Assumes the bank's valid/ready port; drives after rising clk_link_i.
`timescale 1ns/1ns
module fsp_host_model
    import fsp_pkg::*;
(
    // Link clock and reset
    input wire logic clk_link_i,
    input wire logic link_rst_i,
    // Command port
    input wire logic lnk_cmd_ready_i,
    output logic lnk_cmd_valid_o,
    output fsp_pkg::fsp_cmd_t lnk_cmd_o
);
    // Idle port at time zero
    initial
    begin
        lnk_cmd_valid_o = 1'b0;
        lnk_cmd_o = '0;
    end

    // Bounded wait for the port to show ready
    task automatic wait_ready();
        int n = 0;
        do
        begin
            @(posedge clk_link_i);
            #1;
            n++;
        end
        while (lnk_cmd_ready_i !== 1'b1 && n < 200);
        @(posedge clk_link_i);
    endtask

    // One command, held until taken, then the bus is scrambled
    // caller keeps enable-then-write order
    task automatic send(input logic [7:0] op, input logic [7:0] b0);
        wait_ready();
        lnk_cmd_valid_o <= 1'b1;
        lnk_cmd_o <= '{op, b0, 8'h00, 8'h00, 2'h1};
        do
            @(posedge clk_link_i);
        while (lnk_cmd_ready_i !== 1'b1);
        lnk_cmd_valid_o <= 1'b0;
        lnk_cmd_o <= ~lnk_cmd_o;
        wait_ready();
    endtask
endmodule // fsp_host_model

// ---- tb/tb_fsp_status_bank.sv ----
// Self-checking bench of the status and protection bank.
// Assumes the host model above and a behavioural engine done pulse.
`timescale 1ns/1ns
module tb_fsp_status_bank;
    import fsp_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b0;
        logic [1:0] sel;
        logic [7:0] exp;
    } fsp_row_t;
    logic clk_sys_i, sys_rst_i, clk_link_i, link_rst_i;
    logic valid, ready, wp_n, done, hit;
    fsp_cmd_t cmd;
    logic [19:0] addr;
    logic [7:0] sr1, sr2, sr3, eng_op;
    logic pin_rst, pin_hold, wpa, quad, hsq, start;
    logic [1:0] drv;
    logic [2:0] otp;
    int failures, checks;
    int starts = 0;
    fsp_row_t rows [15] = '{
        '{8'h06, 8'h00, 2'h0, 8'h02}, '{8'h04, 8'h00, 2'h0, 8'h00},
        '{8'h06, 8'h00, 2'h0, 8'h02}, '{8'h01, 8'h7F, 2'h0, 8'h7C},
        '{8'h50, 8'h00, 2'h0, 8'h7C}, '{8'h01, 8'h00, 2'h0, 8'h00},
        '{8'h99, 8'h00, 2'h0, 8'h7C}, '{8'h06, 8'h00, 2'h0, 8'h7E},
        '{8'h31, 8'h78, 2'h1, 8'h78}, '{8'h06, 8'h00, 2'h1, 8'h78},
        '{8'h31, 8'h00, 2'h1, 8'h38}, '{8'h06, 8'h00, 2'h2, 8'h00},
        '{8'h11, 8'hFF, 2'h2, 8'hF0}, '{8'h06, 8'h00, 2'h0, 8'h7E},
        '{8'h01, 8'h90, 2'h0, 8'h90}};

    // Clocks, unrelated in phase
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        clk_link_i = 1'b0;
        #7;
        forever #15 clk_link_i = ~clk_link_i;
    end

    fsp_status_bank dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .clk_link_i(clk_link_i), .link_rst_i(link_rst_i),
        .lnk_cmd_valid_i(valid), .lnk_cmd_i(cmd), .lnk_cmd_ready_o(ready),
        .wp_n_i(wp_n), .eng_start_o(start), .eng_op_o(eng_op),
        .eng_done_i(done), .eng_addr_i(addr), .eng_prot_hit_o(hit),
        .status_protect_reg_o(sr1), .status_lock_config_reg_o(sr2),
        .pin_drive_config_reg_o(sr3), .shared_pin_is_reset_o(pin_rst),
        .shared_pin_is_hold_o(pin_hold), .wp_pin_active_o(wpa),
        .quad_io_enable_o(quad), .drive_strength_o(drv),
        .high_speed_quad_mode_o(hsq), .otp_lock_o(otp));
    fsp_host_model host (.clk_link_i(clk_link_i), .link_rst_i(link_rst_i),
        .lnk_cmd_ready_i(ready), .lnk_cmd_valid_o(valid), .lnk_cmd_o(cmd));

    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One command, then optionally wait out busy
    task automatic do_cmd(input logic [7:0] op, input logic [7:0] b0,
                          input bit wb);
        int n = 0;
        host.send(op, b0);
        repeat (8) @(posedge clk_sys_i);
        while (wb && sr1[0] !== 1'b0 && n < 700)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n == 700)
            failures++;
        repeat (3) @(posedge clk_sys_i);
    endtask

    // Count engine start pulses, one per cycle high
    always @(posedge clk_sys_i)
        if (start === 1'b1)
            starts++;

    // Watchdog on a hung run
    initial
    begin
        #400000;
        failures++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        failures = 0;
        checks = 0;
        sys_rst_i = 1'b1;
        link_rst_i = 1'b1;
        wp_n = 1'b1;
        done = 1'b0;
        addr = 20'hFFFFF;
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        link_rst_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        check(sr1, 8'h00);
        check(sr2, 8'h00);
        check(sr3, 8'h00);
        foreach (rows[i])
        begin
            do_cmd(rows[i].op, rows[i].b0, 1'b1);
            check(rows[i].sel == 2'h0 ? sr1 : rows[i].sel == 2'h1 ? sr2 : sr3,
                  rows[i].exp);
        end
        // Pin and driver levels from the second and third bytes, quad off
        check({6'h00, pin_rst, pin_hold}, 8'h02);
        check({6'h00, drv}, 8'h03);
        check({7'h00, hsq}, 8'h01);
        check({5'h00, otp}, 8'h07);
        check({6'h00, wpa, quad}, 8'h02);
        // Upper half protected by blocks from the top
        check({7'h00, hit}, 8'h01);
        addr <= 20'h00000;
        repeat (3) @(posedge clk_sys_i);
        check({7'h00, hit}, 8'h00);
        // Lock mode with the pin low, then high
        wp_n <= 1'b0;
        do_cmd(8'h06, 8'h00, 1'b0);
        do_cmd(8'h01, 8'h84, 1'b1);
        check(sr1, 8'h90);
        wp_n <= 1'b1;
        do_cmd(8'h06, 8'h00, 1'b0);
        do_cmd(8'h01, 8'h00, 1'b1);
        check(sr1, 8'h00);
        // Engine operation, refused command, suspend and resume
        do_cmd(8'h06, 8'h00, 1'b0);
        do_cmd(8'h02, 8'h00, 1'b0);
        check(sr1, 8'h01);
        check(eng_op, 8'h02);
        do_cmd(8'h06, 8'h00, 1'b0);
        check(sr1, 8'h01);
        do_cmd(8'h75, 8'h00, 1'b0);
        check(sr2, 8'hB8);
        do_cmd(8'h7A, 8'h00, 1'b0);
        check(sr2, 8'h38);
        done <= 1'b1;
        @(posedge clk_sys_i);
        done <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        check(sr1, 8'h00);
        // Volatile quad enable hands the pins over to data
        do_cmd(8'h50, 8'h00, 1'b0);
        do_cmd(8'h31, 8'h02, 1'b0);
        check(sr2, 8'h3A);
        check({6'h00, wpa, quad}, 8'h01);
        check({6'h00, pin_rst, pin_hold}, 8'h00);
        check(8'(starts), 8'h03);
        finish_test();
    end
endmodule // tb_fsp_status_bank
